// ---- core/pio_pkg.sv ----
// Constants, types and address decode for the peripheral I/O area access path
package pio_pkg;
    // Peripheral I/O window, 4 KB
    localparam logic [31:0] AREA_BASE = 32'h03FFF000;
    localparam logic [31:0] AREA_LAST = 32'h03FFFFFF;
    localparam int AREA_BYTES = 4096;
    // Step from lower to upper halfword of a split word
    localparam logic [31:0] HALF_STEP = 32'h00000002;
    // Mask clearing the two lowest address bits
    localparam logic [31:0] WORD_MASK = 32'hFFFFFFFC;
    // Halfword bus byte enables
    localparam logic [1:0] BE_NONE = 2'h0;
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_BOTH = 2'h3;
    // Reset values
    localparam logic [31:0] ADDR_RST = 32'h00000000;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    localparam logic [15:0] HALF_RST = 16'h0000;

    // Access size from the CPU data bus
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD
    } size_t;

    // True when the address falls inside the peripheral window
    function automatic logic in_area(input logic [31:0] addr);
        in_area = (addr >= AREA_BASE) && (addr <= AREA_LAST);
    endfunction
endpackage

// ---- core/fetch_if.sv ----
// Fetch request and verdict signals between the bridge and its fetch guard
`timescale 1ns/1ps
interface fetch_if;
    logic req;         // Fetch request
    logic [31:0] addr; // Fetch address
    logic spec;        // Request is a speculative prefetch
    logic pass;        // Fetch forwarded to memory
    logic err;         // Demand fetch refused
    logic void_f;      // Speculative fetch dropped
    modport guard (input req, input addr, input spec, output pass, output err, output void_f);
    modport user (output req, output addr, output spec, input pass, input err, input void_f);
endinterface

// ---- core/fetch_guard.sv ----
// Instruction fetch guard keeping fetches out of the peripheral window
`timescale 1ns/1ps
module fetch_guard (
    input wire logic clk,   // System clock
    input wire logic nrst,  // Synchronous reset, active low
    fetch_if.guard fi       // Fetch request and verdict
);
    logic pass_q;
    logic err_q;
    logic void_q;
    logic hit;

    assign hit = pio_pkg::in_area(fi.addr);

    // Verdict pulses one cycle after each request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pass_q <= 1'b0;
            err_q <= 1'b0;
            void_q <= 1'b0;
        end else begin
            pass_q <= fi.req && !hit;
            err_q <= fi.req && hit && !fi.spec;
            void_q <= fi.req && hit && fi.spec;
        end
    end

    assign fi.pass = pass_q;
    assign fi.err = err_q;
    assign fi.void_f = void_q;

    // Fetches inside the window never pass
    a_no_area_fetch: assert property (@(posedge clk) disable iff (!nrst)
        fi.req && hit |=> !fi.pass && (fi.err || fi.void_f))
        else $error("fetch inside peripheral area was passed");
    // Prefetch at end of RAM does not cross into the window
    a_spec_dropped: assert property (@(posedge clk) disable iff (!nrst)
        fi.req && fi.spec && hit |=> fi.void_f && !fi.err)
        else $error("speculative fetch into peripheral area not dropped");
    // Fetches outside the window pass
    a_outside_pass: assert property (@(posedge clk) disable iff (!nrst)
        fi.req && !hit |=> fi.pass)
        else $error("fetch outside peripheral area not passed");
endmodule

// ---- core/pio_bridge.sv ----
// CPU to on-chip peripheral I/O area bridge with halfword bus splitting
// Summary of operation
// - The window 03FFF000H to 03FFFFFFH is the peripheral area and fetches from it are never served.
// - A word access becomes two halfword cycles, lower then upper, with address bits 1:0 ignored.
// - A halfword access to a byte register writes only the low byte and reads an undefined high byte.
// - A prefetch from the top of internal RAM never crosses into the peripheral window.
`timescale 1ns/1ps
module pio_bridge (
    input wire logic clk,             // System clock, 10 MHz
    input wire logic nrst,            // Synchronous reset, active low
    input wire logic d_req,           // Data access request
    input wire logic [31:0] d_addr,   // Data access address
    input wire pio_pkg::size_t d_size, // Access size
    input wire logic d_we,            // Write when high
    input wire logic [31:0] d_wdata,  // Write data, low aligned
    output logic d_hit,               // Address is in the window
    output logic d_ready,             // Bridge can take a request
    output logic d_ack,               // Access complete pulse
    output logic [31:0] d_rdata,      // Read data
    input wire logic f_req,           // Fetch request
    input wire logic [31:0] f_addr,   // Fetch address
    input wire logic f_spec,          // Fetch is speculative
    output logic f_pass,              // Fetch forwarded to memory
    output logic f_err,               // Fetch refused
    output logic f_void,              // Speculative fetch dropped
    output logic p_req,               // Peripheral cycle request
    output logic [31:0] p_addr,       // Peripheral halfword address
    output logic p_we,                // Peripheral write
    output logic [1:0] p_be,          // Peripheral byte enables
    output logic [15:0] p_wdata,      // Peripheral write data
    input wire logic [15:0] p_rdata,  // Peripheral read data
    input wire logic p_ack,           // Peripheral cycle done
    input wire logic p_byte_reg       // Addressed register is byte wide
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } state_t;

    state_t state_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [15:0] low_q;
    pio_pkg::size_t size_q;
    logic we_q;
    logic take;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] be_raw;

    fetch_if fi ();

    // Fetch path through the guard
    assign fi.req = f_req;
    assign fi.addr = f_addr;
    assign fi.spec = f_spec;
    assign f_pass = fi.pass;
    assign f_err = fi.err;
    assign f_void = fi.void_f;

    fetch_guard u_guard (
        .clk(clk),
        .nrst(nrst),
        .fi(fi)
    );

    // Claim of the window and request acceptance
    assign d_hit = pio_pkg::in_area(d_addr);
    assign d_ready = (state_q == ST_IDLE);
    assign take = d_req && d_hit && d_ready;

    // Access sequencing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (p_ack && size_q == pio_pkg::SZ_WORD) begin
                        state_q <= ST_HIGH;
                    end else if (p_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HIGH: begin
                    if (p_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Captured access and address stepping
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_q <= pio_pkg::ADDR_RST;
            wdata_q <= pio_pkg::DATA_RST;
            size_q <= pio_pkg::SZ_BYTE;
            we_q <= 1'b0;
        end else if (take) begin
            size_q <= d_size;
            we_q <= d_we;
            wdata_q <= d_wdata;
            if (d_size == pio_pkg::SZ_WORD) begin
                addr_q <= d_addr & pio_pkg::WORD_MASK;
            end else begin
                addr_q <= d_addr;
            end
        end else if (state_q == ST_LOW && p_ack && size_q == pio_pkg::SZ_WORD) begin
            addr_q <= addr_q + pio_pkg::HALF_STEP;
        end
    end

    // Lower halfword kept while the upper one is read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            low_q <= pio_pkg::HALF_RST;
        end else if (state_q == ST_LOW && p_ack) begin
            low_q <= p_rdata;
        end
    end

    // Completion pulse and assembled read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= pio_pkg::DATA_RST;
        end else begin
            ack_q <= p_ack && (state_q == ST_HIGH || (state_q == ST_LOW && size_q != pio_pkg::SZ_WORD));
            if (state_q == ST_HIGH && p_ack) begin
                rdata_q <= {p_rdata, low_q};
            end else if (state_q == ST_LOW && p_ack && size_q == pio_pkg::SZ_HALF) begin
                rdata_q <= {16'h0000, p_rdata};
            end else if (state_q == ST_LOW && p_ack && size_q == pio_pkg::SZ_BYTE) begin
                rdata_q <= {24'h000000, addr_q[0] ? p_rdata[15:8] : p_rdata[7:0]};
            end
        end
    end

    assign d_ack = ack_q;
    assign d_rdata = rdata_q;

    // Halfword bus drive
    assign p_req = (state_q == ST_LOW) || (state_q == ST_HIGH);
    assign p_addr = addr_q;
    assign p_we = we_q && p_req;
    assign p_wdata = (state_q == ST_HIGH) ? wdata_q[31:16] :
        (size_q == pio_pkg::SZ_BYTE ? {wdata_q[7:0], wdata_q[7:0]} : wdata_q[15:0]);

    // Byte enables, narrowed to the low byte for halfword and word accesses to byte-wide registers
    always_comb begin
        be_raw = pio_pkg::BE_BOTH;
        if (size_q == pio_pkg::SZ_BYTE) begin
            be_raw = addr_q[0] ? pio_pkg::BE_HIGH : pio_pkg::BE_LOW;
        end
        if (!p_req) begin
            p_be = pio_pkg::BE_NONE;
        end else if (p_byte_reg && size_q != pio_pkg::SZ_BYTE) begin
            p_be = pio_pkg::BE_LOW;
        end else begin
            p_be = be_raw;
        end
    end

    // Word split: low cycle, then high cycle at base plus two
    sequence s_low_done;
        state_q == ST_LOW && p_ack && size_q == pio_pkg::SZ_WORD;
    endsequence
    sequence s_high_start;
        state_q == ST_HIGH && p_req && p_addr[1:0] == 2'b10;
    endsequence

    a_word_split: assert property (@(posedge clk) disable iff (!nrst)
        s_low_done |=> s_high_start)
        else $error("word access did not move to upper halfword");
    a_word_base: assert property (@(posedge clk) disable iff (!nrst)
        take && d_size == pio_pkg::SZ_WORD |=> p_req && p_addr == ($past(d_addr) & pio_pkg::WORD_MASK))
        else $error("first word half not at aligned base");
    a_high_addr: assert property (@(posedge clk) disable iff (!nrst)
        s_low_done |=> p_addr == $past(p_addr) + pio_pkg::HALF_STEP)
        else $error("second word half not at base plus two");
    a_word_data: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_HIGH && p_ack |=> d_ack && d_rdata == {$past(p_rdata), low_q})
        else $error("word read not assembled from both halves");
    a_byte_reg_write: assert property (@(posedge clk) disable iff (!nrst)
        p_req && p_byte_reg && size_q == pio_pkg::SZ_HALF |-> p_be == pio_pkg::BE_LOW)
        else $error("halfword write to byte register touched high byte");
    a_area_only: assert property (@(posedge clk) disable iff (!nrst)
        d_req && !d_hit && d_ready |=> state_q == ST_IDLE)
        else $error("access outside peripheral area was taken");

    // Bridge busy and requesting a cycle right after take
    a_busy_after_take: assert property (@(posedge clk) disable iff (!nrst)
        take |=> !d_ready && p_req)
        else $error("bridge ready again right after taking a request");
    // Word halves to a byte register are narrowed too
    a_word_byte_reg: assert property (@(posedge clk) disable iff (!nrst)
        p_req && p_byte_reg && size_q == pio_pkg::SZ_WORD |-> p_be == pio_pkg::BE_LOW)
        else $error("word half to byte register touched high byte");
    // Halfword read handed over as received
    a_half_read: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_LOW && p_ack && size_q == pio_pkg::SZ_HALF |=> d_ack && d_rdata[15:0] == $past(p_rdata))
        else $error("halfword read data not passed through");
    // Completion is a single-cycle pulse
    a_ack_single: assert property (@(posedge clk) disable iff (!nrst)
        d_ack |=> !d_ack)
        else $error("completion pulse longer than one cycle");
    // Byte enables and write quiet between cycles
    a_idle_no_be: assert property (@(posedge clk) disable iff (!nrst)
        !p_req |-> p_be == pio_pkg::BE_NONE && !p_we)
        else $error("byte enables active with no cycle");
endmodule

// ---- testbench/periph_model.sv ----
// Peripheral side model: halfword registers with optional wait states
`timescale 1ns/1ps
module periph_model (
    input wire logic clk,            // System clock
    input wire logic nrst,           // Synchronous reset, active low
    input wire logic slow,           // Insert wait states
    input wire logic p_req,          // Cycle request
    input wire logic [31:0] p_addr,  // Halfword address
    input wire logic p_we,           // Write
    input wire logic [1:0] p_be,     // Byte enables
    input wire logic [15:0] p_wdata, // Write data
    output logic [15:0] p_rdata,     // Read data
    output logic p_ack,              // Cycle done
    output logic p_byte_reg          // Register is byte wide
);
    logic [15:0] mem [0:2047];
    logic [1:0] wait_q;
    logic [15:0] junk_q;
    logic [10:0] idx;
    initial for (int i = 0; i < 2048; i++) mem[i] = 16'h0000;
    // Top 256 bytes of the window hold byte-wide registers
    assign idx = p_addr[11:1];
    assign p_byte_reg = p_addr[11:8] == 4'hF;
    assign p_ack = p_req && wait_q == 2'h0;
    // Undefined high byte on narrowed reads; a changing pattern when idle
    assign p_rdata = !p_ack ? junk_q : (p_byte_reg && p_be == 2'h1) ? {junk_q[15:8], mem[idx][7:0]} : mem[idx];
    // Wait states, write lanes and idle pattern
    always @(posedge clk) begin
        junk_q <= !nrst ? 16'h5A3C : ~junk_q;
        if (!nrst) wait_q <= 2'h0;
        else if (p_ack) wait_q <= slow ? 2'($urandom_range(2)) : 2'h0;
        else if (p_req) wait_q <= wait_q - 2'h1;
        if (p_ack && p_we && p_be[0]) mem[idx][7:0] <= p_wdata[7:0];
        if (p_ack && p_we && p_be[1]) mem[idx][15:8] <= p_wdata[15:8];
    end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the peripheral I/O area bridge
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0, nrst = 1'h0, d_req = 1'h0, d_we = 1'h0, f_req = 1'h0, f_spec = 1'h0, slow = 1'h0;
    logic [31:0] d_addr = '0, d_wdata = '0, f_addr = '0, d_rdata, p_addr;
    pio_pkg::size_t d_size = pio_pkg::SZ_BYTE;
    logic d_hit, d_ready, d_ack, f_pass, f_err, f_void, p_req, p_we, p_ack, p_byte_reg;
    logic [1:0] p_be;
    logic [15:0] p_wdata, p_rdata;
    logic [15:0] rm [0:2047];
    logic [32:0] ecq[$], ocq[$];
    int bad_count = 0, n_tests = 0, cyc = 0;
    pio_bridge pio_bridge_i (.clk(clk), .nrst(nrst), .d_req(d_req), .d_addr(d_addr), .d_size(d_size),
        .d_we(d_we), .d_wdata(d_wdata), .d_hit(d_hit), .d_ready(d_ready), .d_ack(d_ack), .d_rdata(d_rdata),
        .f_req(f_req), .f_addr(f_addr), .f_spec(f_spec), .f_pass(f_pass), .f_err(f_err), .f_void(f_void),
        .p_req(p_req), .p_addr(p_addr), .p_we(p_we), .p_be(p_be), .p_wdata(p_wdata), .p_rdata(p_rdata),
        .p_ack(p_ack), .p_byte_reg(p_byte_reg));
    periph_model periph_model_i (.clk(clk), .nrst(nrst), .slow(slow), .p_req(p_req), .p_addr(p_addr),
        .p_we(p_we), .p_be(p_be), .p_wdata(p_wdata), .p_rdata(p_rdata), .p_ack(p_ack), .p_byte_reg(p_byte_reg));
    // Clock at 10 MHz
    always #50 clk = ~clk;
    // Log of completed peripheral cycles
    always @(negedge clk) if (p_req === 1'h1 && p_ack === 1'h1) ocq.push_back({p_addr[31:1], p_be});
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic note(input logic ok, input string what);
        n_tests++;
        if (!ok) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic chk_data(input logic [31:0] got, exp, msk);
        note((got & msk) === (exp & msk), $sformatf("data %h exp %h", got, exp));
    endtask
    task automatic chk_cyc(input logic [32:0] got, exp);
        note(got === exp, $sformatf("cycle %h exp %h", got, exp));
    endtask
    task automatic chk_fetch(input logic [2:0] got, exp);
        note(got === exp, $sformatf("fetch %b exp %b", got, exp));
    endtask
    // One data access; expectations come from the reference array
    task automatic access(input pio_pkg::size_t sz, input logic we, input logic [31:0] a, wd);
        logic [31:0] ha, e, m;
        logic [15:0] hd, rd;
        logic [1:0] be;
        logic br;
        int n;
        e = '0;
        m = sz == pio_pkg::SZ_HALF ? 32'hFFFF0000 : '0;
        ecq.delete();
        ocq.delete();
        for (int k = 0; k < (sz == pio_pkg::SZ_WORD ? 2 : 1); k++) begin
            ha = sz == pio_pkg::SZ_WORD ? (a & 32'hFFFFFFFC) + 32'h2 * k : a;
            br = ha[11:8] == 4'hF;
            be = sz == pio_pkg::SZ_BYTE ? (ha[0] ? 2'h2 : 2'h1) : (br ? 2'h1 : 2'h3);
            hd = sz == pio_pkg::SZ_BYTE ? {2{wd[7:0]}} : (k != 0 ? wd[31:16] : wd[15:0]);
            ecq.push_back({ha[31:1], be});
            if (we && be[0]) rm[ha[11:1]][7:0] = hd[7:0];
            if (we && be[1]) rm[ha[11:1]][15:8] = hd[15:8];
            rd = rm[ha[11:1]];
            if (sz == pio_pkg::SZ_BYTE) begin
                e = {24'h0, ha[0] ? rd[15:8] : rd[7:0]};
                m = 32'hFFFFFFFF;
            end else begin
                e = e | ({16'h0, rd} << (16 * k));
                m = m | ((br ? 32'h00FF : 32'hFFFF) << (16 * k));
            end
        end
        @(posedge clk);
        #1;
        d_req = 1'h1;
        d_addr = a;
        d_size = sz;
        d_we = we;
        d_wdata = wd;
        slow = 1'($urandom_range(1));
        @(posedge clk);
        #1;
        d_req = 1'h0;
        note(d_ready === 1'h0, "busy");
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (d_ack !== 1'h1 && n < 40);
        note(n < 40, "no completion");
        note(d_ready === 1'h1, "ready");
        if (!we) chk_data(d_rdata, e, m);
        note(ocq.size() == ecq.size(), "cycle count");
        foreach (ecq[i]) chk_cyc(ocq[i], ecq[i]);
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [31:0] a;
        logic [31:0] tb [6];
        pio_pkg::size_t sz;
        logic in;
        void'($urandom(32'hD56A90F8));
        for (int i = 0; i < 2048; i++) rm[i] = 16'h0000;
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'h1;
        // Request just below the window is never answered
        d_addr = pio_pkg::AREA_BASE - 32'h2;
        d_req = 1'h1;
        repeat (4) @(negedge clk) note(d_ack !== 1'h1 && ocq.size() == 0 && d_hit === 1'h0 &&
            d_ready === 1'h1, "refused");
        @(posedge clk);
        #1;
        d_req = 1'h0;
        tb = '{pio_pkg::AREA_BASE, pio_pkg::AREA_LAST, pio_pkg::AREA_BASE - 32'h1, pio_pkg::AREA_LAST + 32'h1, '0, '0};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            d_addr = tb[i];
            @(negedge clk);
            chk_data({31'h0, d_hit}, {31'h0, i < 2}, 32'h1);
        end
        access(pio_pkg::SZ_WORD, 1'h1, pio_pkg::AREA_BASE + 32'h13, 32'hA1B2C3D4);
        access(pio_pkg::SZ_WORD, 1'h0, pio_pkg::AREA_BASE + 32'h10, '0);
        access(pio_pkg::SZ_WORD, 1'h1, pio_pkg::AREA_BASE + 32'hF20, 32'h55667788);
        access(pio_pkg::SZ_HALF, 1'h0, pio_pkg::AREA_BASE + 32'hF20, '0);
        // Random traffic confined to the window
        repeat (80) begin
            a = pio_pkg::AREA_BASE + 32'($urandom_range(4095));
            sz = pio_pkg::size_t'($urandom_range(2));
            if (sz == pio_pkg::SZ_HALF) a[0] = 1'h0;
            access(sz, 1'($urandom_range(1)), a, $urandom());
        end
        // Fetches around both window edges, demand and speculative
        tb = '{pio_pkg::AREA_BASE - 32'h4, pio_pkg::AREA_BASE - 32'h2, pio_pkg::AREA_BASE,
            pio_pkg::AREA_BASE + 32'($urandom_range(4095)), pio_pkg::AREA_LAST - 32'h1, pio_pkg::AREA_LAST + 32'h1};
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            #1;
            f_req = 1'h1;
            f_spec = 1'(i / 6 % 2);
            f_addr = tb[i % 6];
            @(posedge clk);
            @(negedge clk);
            in = f_addr >= 32'h03FFF000 && f_addr <= 32'h03FFFFFF;
            chk_fetch({f_pass, f_err, f_void}, {!in, in && !f_spec, in && f_spec});
        end
        @(posedge clk);
        #1;
        f_req = 1'h0;
        results();
    end
endmodule
